/* include/ies_pkg.sv */
// constants and types of the interrupt entry sequencer
package ies_pkg;
   localparam int NSRC = 8;
   localparam int PCW  = 12;
   localparam int VIW  = 4;

   // register indices on the plain register port
   localparam logic [3:0] A_STATUS = 4'h0;
   localparam logic [3:0] A_CTRL   = 4'h1;
   localparam logic [3:0] A_EN     = 4'h2;
   localparam logic [3:0] A_FLAG   = 4'h3;
   localparam logic [3:0] A_PEND   = 4'h4;
   localparam logic [3:0] A_SPL    = 4'h5;
   localparam logic [3:0] A_SPH    = 4'h6;
   localparam logic [3:0] A_SEQ    = 4'h7;

   localparam int GIE_BIT   = 7;
   localparam int RELOC_BIT = 1;

   // cycle counts as count minus one, loaded for entry, wake and return, counted up to for the reset wait
   localparam logic [3:0] ENTRY_LAST = 4'h3;
   localparam logic [3:0] WAKE_LAST  = 4'h7;
   localparam logic [3:0] RET_LAST   = 4'h3;
   localparam logic [3:0] RST_WAIT   = 4'h5;
   localparam logic [3:0] CNT_HI     = 4'h3;
   localparam logic [3:0] CNT_SP     = 4'h2;
   localparam logic [3:0] CNT_LO     = 4'h1;
   localparam logic [15:0] SP_ONE    = 16'h0001;
   localparam logic [15:0] SP_TWO    = 16'h0002;
   localparam logic [PCW-1:0] RST_PC = 12'h000;

   typedef enum logic [2:0] {
      S_RST = 3'b000,
      S_RUN = 3'b001,
      S_ENT = 3'b010,
      S_RET = 3'b011
   } ies_state_t;

   typedef enum logic [2:0] {
      OP_ADD = 3'b000,
      OP_SUB = 3'b001,
      OP_AND = 3'b010,
      OP_OR  = 3'b011,
      OP_XOR = 3'b100,
      OP_MOV = 3'b101
   } ies_op_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ies_bus_t;

   typedef struct packed {
      ies_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic [4:0] dst;
      logic       go;
   } ies_alu_t;

   typedef struct packed {
      ies_state_t     state;
      logic [3:0]     cnt;
      logic           gie;
      logic [6:0]     stat;
      logic           vector_relocate_select;
      logic [NSRC-1:0] en;
      logic [NSRC-1:0] flag;
      logic           block;
      logic           wake;
      logic [VIW-1:0] vec;
      logic [15:0]    sp;
      logic [PCW-1:0] ret_pc;
      logic [2:0]     fz_s;
      logic [2:0]     la_s;
      logic [2:0]     lb_s;
      logic           fz;
      logic           la;
      logic           lb;
      logic           stall;
      logic           pc_load;
      logic [PCW-1:0] pc_vec;
      logic           stk_we;
      logic           stk_re;
      logic [15:0]    stk_addr;
      logic [7:0]     stk_wdata;
      logic [7:0]     rdata;
      logic           alu_wr;
      logic [4:0]     alu_dst;
      logic [7:0]     alu_res;
   } ies_st_t;
endpackage : ies_pkg

/* hw/ies_core.sv */
// interrupt entry and return sequencer with register port and alu stage
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ies_core #(
   parameter logic [ies_pkg::NSRC-1:0] FLAG_TYPE = 8'h7F,
   parameter logic [ies_pkg::PCW-1:0]  BOOT_BASE = 12'hC00,
   parameter logic [ies_pkg::PCW-1:0]  VEC_STEP  = 12'h001
) (
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   input  wire ies_pkg::ies_bus_t        bus_i,
   output      logic [7:0]               rdata_o,
   input  wire logic [ies_pkg::NSRC-1:0] src_event_i,
   input  wire logic [ies_pkg::NSRC-1:0] src_level_i,
   input  wire logic                     instr_boundary_i,
   input  wire logic                     sei_i,
   input  wire logic                     cli_i,
   input  wire logic                     return_from_irq_op_i,
   input  wire logic                     sleep_i,
   input  wire logic [ies_pkg::PCW-1:0]  pc_i,
   input  wire logic [7:0]               stk_rdata_i,
   input  wire ies_pkg::ies_alu_t        alu_i,
   input  wire logic                     reset_vector_boot_fuse_i,
   input  wire logic                     app_section_lock_bit_i,
   input  wire logic                     boot_section_lock_bit_i,
   output      logic                     stall_o,
   output      logic                     pc_load_o,
   output      logic [ies_pkg::PCW-1:0]  pc_vec_o,
   output      logic                     stk_we_o,
   output      logic                     stk_re_o,
   output      logic [15:0]              stk_addr_o,
   output      logic [7:0]               stk_wdata_o,
   output      logic                     gie_o,
   output      logic                     alu_wr_o,
   output      logic [4:0]               alu_dst_o,
   output      logic [7:0]               alu_res_o
);

   ies_pkg::ies_st_t st_r;
   ies_pkg::ies_st_t st_nxt;

   logic [ies_pkg::NSRC-1:0] pend;
   logic [ies_pkg::NSRC-1:0] req;
   logic [ies_pkg::VIW-1:0]  win;
   logic                     locked;
   logic                     take;
   logic [2:0]               win_idx;

   // lowest set index plus one, zero when nothing requests
   function automatic logic [ies_pkg::VIW-1:0] pick(input logic [ies_pkg::NSRC-1:0] r);
      logic [ies_pkg::VIW-1:0] v;
      v = '0;
      for (int i = ies_pkg::NSRC - 1; i >= 0; i--) begin
         if (r[i]) begin
            v = ies_pkg::VIW'(i + 1);
         end
      end
      return v;
   endfunction : pick

   // vector address, index zero being reset
   function automatic logic [ies_pkg::PCW-1:0] vec_addr(input logic [ies_pkg::VIW-1:0] idx,
                                                        input logic boot);
      logic [ies_pkg::PCW-1:0] base;
      base = boot ? BOOT_BASE : ies_pkg::RST_PC;
      return ies_pkg::PCW'(base + ies_pkg::PCW'(idx) * VEC_STEP);
   endfunction : vec_addr

   function automatic logic [7:0] alu_f(input ies_pkg::ies_op_t op, input logic [7:0] a,
                                        input logic [7:0] b);
      case (op)
         ies_pkg::OP_ADD: return 8'(a + b);
         ies_pkg::OP_SUB: return 8'(a - b);
         ies_pkg::OP_AND: return a & b;
         ies_pkg::OP_OR:  return a | b;
         ies_pkg::OP_XOR: return a ^ b;
         ies_pkg::OP_MOV: return b;
         default:         return 8'h00;
      endcase
   endfunction : alu_f

   always_comb begin
      // flag sources use their flag, level sources the live condition
      pend = (st_r.flag & FLAG_TYPE) | (src_level_i & ~FLAG_TYPE);
      req = pend & st_r.en;
      win = pick(req);
      win_idx = 3'(win - 4'h1);
      locked = (st_r.la && pc_i >= BOOT_BASE && !st_r.vector_relocate_select) ||
               (st_r.lb && pc_i < BOOT_BASE && st_r.vector_relocate_select);
      take = (instr_boundary_i || sleep_i) && !st_r.block && st_r.gie &&
             !cli_i && !locked && (win != '0) && !return_from_irq_op_i;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.pc_load = 1'b0;
      st_nxt.stk_we = 1'b0;
      st_nxt.stk_re = 1'b0;
      st_nxt.rdata = 8'h00;

      // pin straps: three stages, take a change when the last two agree
      st_nxt.fz_s = {st_r.fz_s[1:0], reset_vector_boot_fuse_i};
      st_nxt.la_s = {st_r.la_s[1:0], app_section_lock_bit_i};
      st_nxt.lb_s = {st_r.lb_s[1:0], boot_section_lock_bit_i};
      if (st_r.fz_s[2] == st_r.fz_s[1]) begin
         st_nxt.fz = st_r.fz_s[2];
      end
      if (st_r.la_s[2] == st_r.la_s[1]) begin
         st_nxt.la = st_r.la_s[2];
      end
      if (st_r.lb_s[2] == st_r.lb_s[1]) begin
         st_nxt.lb = st_r.lb_s[2];
      end

      // single-cycle alu write-back
      st_nxt.alu_wr = alu_i.go;
      st_nxt.alu_dst = alu_i.dst;
      st_nxt.alu_res = alu_f(alu_i.op, alu_i.a, alu_i.b);

      // register port
      if (bus_i.wr) begin
         case (bus_i.addr)
            ies_pkg::A_STATUS: begin
               st_nxt.gie = bus_i.wdata[ies_pkg::GIE_BIT];
               st_nxt.stat = bus_i.wdata[ies_pkg::GIE_BIT-1:0];
            end
            ies_pkg::A_CTRL: st_nxt.vector_relocate_select = bus_i.wdata[ies_pkg::RELOC_BIT];
            ies_pkg::A_EN:   st_nxt.en = bus_i.wdata;
            ies_pkg::A_FLAG: st_nxt.flag = st_r.flag & ~bus_i.wdata;
            ies_pkg::A_SPL:  st_nxt.sp[7:0] = bus_i.wdata;
            ies_pkg::A_SPH:  st_nxt.sp[15:8] = bus_i.wdata;
            default: ;
         endcase
      end
      if (bus_i.rd) begin
         case (bus_i.addr)
            ies_pkg::A_STATUS: st_nxt.rdata = {st_r.gie, st_r.stat};
            ies_pkg::A_CTRL:   st_nxt.rdata = {6'h00, st_r.vector_relocate_select, 1'b0};
            ies_pkg::A_EN:     st_nxt.rdata = st_r.en;
            ies_pkg::A_FLAG:   st_nxt.rdata = st_r.flag;
            ies_pkg::A_PEND:   st_nxt.rdata = pend;
            ies_pkg::A_SPL:    st_nxt.rdata = st_r.sp[7:0];
            ies_pkg::A_SPH:    st_nxt.rdata = st_r.sp[15:8];
            ies_pkg::A_SEQ:    st_nxt.rdata = {st_r.state, st_r.block, st_r.wake, 3'h0};
            default:           st_nxt.rdata = 8'h00;
         endcase
      end

      // global enable instructions from the pipeline
      if (sei_i) begin
         st_nxt.gie = 1'b1;
         st_nxt.block = 1'b1;
      end
      if (cli_i) begin
         st_nxt.gie = 1'b0;
      end

      case (st_r.state)
         ies_pkg::S_RST: begin
            st_nxt.cnt = 4'(st_r.cnt + 4'h1);
            if (st_r.cnt == ies_pkg::RST_WAIT) begin
               st_nxt.state = ies_pkg::S_RUN;
               st_nxt.pc_load = 1'b1;
               st_nxt.pc_vec = vec_addr('0, st_r.fz);
            end
         end
         ies_pkg::S_RUN: begin
            if (st_r.block && instr_boundary_i) begin
               st_nxt.block = sei_i;
            end
            if (return_from_irq_op_i) begin
               st_nxt.state = ies_pkg::S_RET;
               st_nxt.cnt = ies_pkg::RET_LAST;
               st_nxt.stk_re = 1'b1;
               st_nxt.stk_addr = 16'(st_r.sp + ies_pkg::SP_ONE);
            end else if (take) begin
               st_nxt.state = ies_pkg::S_ENT;
               st_nxt.wake = sleep_i;
               st_nxt.cnt = sleep_i ? ies_pkg::WAKE_LAST : ies_pkg::ENTRY_LAST;
               st_nxt.gie = 1'b0;
               st_nxt.vec = win;
               st_nxt.ret_pc = pc_i;
               st_nxt.stk_we = 1'b1;
               st_nxt.stk_addr = st_r.sp;
               st_nxt.stk_wdata = pc_i[7:0];
            end
         end
         ies_pkg::S_ENT: begin
            st_nxt.cnt = 4'(st_r.cnt - 4'h1);
            if (st_r.cnt == (st_r.wake ? ies_pkg::WAKE_LAST : ies_pkg::ENTRY_LAST)) begin
               st_nxt.stk_we = 1'b1;
               st_nxt.stk_addr = 16'(st_r.sp - ies_pkg::SP_ONE);
               st_nxt.stk_wdata = 8'(st_r.ret_pc >> 8);
               st_nxt.sp = 16'(st_r.sp - ies_pkg::SP_TWO);
            end
            if (st_r.cnt == '0) begin
               st_nxt.state = ies_pkg::S_RUN;
               st_nxt.wake = 1'b0;
               st_nxt.pc_load = 1'b1;
               st_nxt.pc_vec = vec_addr(st_r.vec, st_r.vector_relocate_select);
            end
         end
         ies_pkg::S_RET: begin
            st_nxt.cnt = 4'(st_r.cnt - 4'h1);
            if (st_r.cnt == ies_pkg::CNT_HI) begin
               st_nxt.stk_re = 1'b1;
               st_nxt.stk_addr = 16'(st_r.sp + ies_pkg::SP_TWO);
            end
            if (st_r.cnt == ies_pkg::CNT_SP) begin
               st_nxt.ret_pc = {stk_rdata_i[ies_pkg::PCW-9:0], st_r.ret_pc[7:0]};
            end
            if (st_r.cnt == ies_pkg::CNT_LO) begin
               st_nxt.ret_pc[7:0] = stk_rdata_i;
               st_nxt.sp = 16'(st_r.sp + ies_pkg::SP_TWO);
            end
            if (st_r.cnt == '0) begin
               st_nxt.state = ies_pkg::S_RUN;
               st_nxt.pc_load = 1'b1;
               st_nxt.pc_vec = st_r.ret_pc;
               st_nxt.gie = 1'b1;
               st_nxt.block = 1'b1;
            end
         end
         default: begin
            st_nxt.state = ies_pkg::S_RUN;
         end
      endcase

      // new events win over any clear in the same cycle
      if (take && FLAG_TYPE[win_idx]) begin
         st_nxt.flag[win_idx] = 1'b0;
      end
      st_nxt.flag = st_nxt.flag | (src_event_i & FLAG_TYPE);
      st_nxt.stall = st_nxt.state != ies_pkg::S_RUN;
   end

   // status low bits untouched by entry and return
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o     = st_r.rdata;
   assign stall_o     = st_r.stall;
   assign pc_load_o   = st_r.pc_load;
   assign pc_vec_o    = st_r.pc_vec;
   assign stk_we_o    = st_r.stk_we;
   assign stk_re_o    = st_r.stk_re;
   assign stk_addr_o  = st_r.stk_addr;
   assign stk_wdata_o = st_r.stk_wdata;
   assign gie_o       = st_r.gie;
   assign alu_wr_o    = st_r.alu_wr;
   assign alu_dst_o   = st_r.alu_dst;
   assign alu_res_o   = st_r.alu_res;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   logic                     ent_start;
   logic                     ret_start;
   logic [ies_pkg::NSRC-1:0] ent_bit;
   // first cycle of entry or return, known from the freshly loaded count
   assign ent_start = st_r.state == ies_pkg::S_ENT &&
                      st_r.cnt == (st_r.wake ? ies_pkg::WAKE_LAST : ies_pkg::ENTRY_LAST);
   assign ret_start = st_r.state == ies_pkg::S_RET && st_r.cnt == ies_pkg::RET_LAST;
   // one-hot of the source being vectored
   assign ent_bit   = ies_pkg::NSRC'(1) << 3'(st_r.vec - 4'h1);

   AST_GIE_CLR: assert property (ent_start |-> !st_r.gie && $past(st_r.gie))
      else $error("entry without global enable or enable not cleared");
   AST_ENTRY_LEN: assert property (ent_start && !st_r.wake |-> !st_r.pc_load [*4] ##1 st_r.pc_load)
      else $error("entry did not take four cycles");
   AST_WAKE_LEN: assert property (ent_start && st_r.wake |-> ##8 st_r.pc_load)
      else $error("wake entry did not take eight cycles");
   AST_SP_DEC: assert property (ent_start |-> ##4 st_r.sp == 16'($past(st_r.sp, 4) - 16'h0002))
      else $error("stack pointer not lowered by two");
   AST_RET: assert property (ret_start |-> ##4 st_r.gie && st_r.pc_load &&
                             st_r.sp == 16'($past(st_r.sp, 4) + 16'h0002))
      else $error("return sequence wrong");
   AST_CLI: assert property (cli_i && st_r.state == ies_pkg::S_RUN |=> st_r.state != ies_pkg::S_ENT)
      else $error("interrupt taken with global clear");
   AST_SHADOW: assert property (st_r.block |=> st_r.state != ies_pkg::S_ENT)
      else $error("interrupt taken inside the one-instruction shadow");
   AST_FLAG_CLR: assert property (bus_i.wr && bus_i.addr == ies_pkg::A_FLAG && bus_i.wdata[0] &&
                                  !src_event_i[0] |=> !st_r.flag[0])
      else $error("write one did not clear flag");
   AST_VEC: assert property (ent_start && !st_r.wake |-> ##4
                             st_r.pc_vec == vec_addr($past(st_r.vec, 4),
                                                     $past(st_r.vector_relocate_select, 4)))
      else $error("wrong vector address");
   AST_EN_GATE: assert property (ent_start |-> ($past(st_r.en) & ent_bit) != '0)
      else $error("entry for a source without its enable");
   AST_PRIO: assert property (ent_start |-> ($past(req) & (ent_bit - ies_pkg::NSRC'(1))) == '0)
      else $error("a lower vector was requesting and lost");
   AST_FLAG_HW: assert property (ent_start && (FLAG_TYPE & ent_bit) != '0 && $past(src_event_i) == '0
                                 |-> (st_r.flag & ent_bit) == '0)
      else $error("flag of vectored source not cleared");
   AST_RST_VEC: assert property (st_r.state == ies_pkg::S_RST && st_r.cnt == ies_pkg::RST_WAIT |=>
                                 st_r.pc_load && st_r.pc_vec == ($past(st_r.fz) ? BOOT_BASE : ies_pkg::RST_PC))
      else $error("wrong reset vector");
   AST_ALU: assert property (alu_i.go && alu_i.op == ies_pkg::OP_ADD |=>
                             st_r.alu_wr && st_r.alu_res == 8'($past(alu_i.a) + $past(alu_i.b)))
      else $error("alu result not written back in one cycle");
   AST_PUSH: assert property (ent_start |-> (st_r.stk_we && st_r.stk_addr == st_r.sp) ##1
                              (st_r.stk_we && st_r.stk_addr == 16'(st_r.sp + 16'h0001)))
      else $error("return address not pushed low byte then high byte");
   AST_POP: assert property (ret_start |-> (st_r.stk_re && st_r.stk_addr == 16'(st_r.sp + 16'h0001)) ##1
                             (st_r.stk_re && st_r.stk_addr == 16'(st_r.sp + 16'h0002)))
      else $error("return address not popped from the stack");
   AST_STALL: assert property (st_r.state == ies_pkg::S_ENT || st_r.state == ies_pkg::S_RET |->
                               st_r.stall)
      else $error("pipeline not stalled during entry or return");
   AST_RDATA: assert property (!bus_i.rd |=> st_r.rdata == 8'h00)
      else $error("read data stood longer than one cycle");
   AST_LOCK: assert property (locked && st_r.state == ies_pkg::S_RUN |=> st_r.state != ies_pkg::S_ENT)
      else $error("interrupt taken while locked");
   AST_GIE_GATE: assert property (!st_r.gie && st_r.state == ies_pkg::S_RUN |=>
                                  st_r.state != ies_pkg::S_ENT)
      else $error("interrupt taken with global enable clear");
   AST_BOUNDARY: assert property (st_r.state == ies_pkg::S_RUN && !instr_boundary_i && !sleep_i |=>
                                  st_r.state != ies_pkg::S_ENT)
      else $error("interrupt taken away from an instruction boundary");
   AST_SEI: assert property (sei_i && !cli_i && !st_r.gie && st_r.state == ies_pkg::S_RUN |=>
                             st_r.gie && st_r.block)
      else $error("global set did not open a one-instruction shadow");

   COV_ENTRY: cover property (ent_start && !st_r.wake);
   COV_WAKE: cover property (ent_start && st_r.wake);
   COV_RET: cover property (ret_start);
   COV_RELOC: cover property (ent_start && st_r.vector_relocate_select);
   COV_LOCK: cover property (locked && instr_boundary_i && req != '0);

endmodule : ies_core

/* dv/ies_stack_model.sv */
// stack memory on the pipeline side of the sequencer
`timescale 1ns/1ps
module ies_stack_model (
   input  wire logic        clock_i,
   input  wire logic        stk_we_i,
   input  wire logic        stk_re_i,
   input  wire logic [15:0] stk_addr_i,
   input  wire logic [7:0]  stk_wdata_i,
   output      logic [7:0]  stk_rdata_o
);
   logic [7:0] mem [0:1023];
   initial stk_rdata_o = 8'h00;
   always @(posedge clock_i) begin
      if (stk_we_i) begin
         mem[stk_addr_i[9:0]] <= stk_wdata_i;
      end
      // data stand one cycle only, then toggle so stale bytes cannot pass
      if (stk_re_i) begin
         stk_rdata_o <= mem[stk_addr_i[9:0]];
      end else begin
         stk_rdata_o <= ~stk_rdata_o;
      end
   end
endmodule : ies_stack_model

/* dv/interrupt_entry_sequencer_bench.sv */
// self-checking bench of the interrupt entry sequencer
`timescale 1ns/1ps
module interrupt_entry_sequencer_bench;
   logic                  clock_i, rst_n_i, bnd, sei, cli, ret_op, slp, fuse, alock, blk;
   logic                  stall, pc_load, stk_we, stk_re, gie, alu_wr;
   ies_pkg::ies_bus_t     bus;
   ies_pkg::ies_alu_t     alu;
   logic [7:0]            ev, lvl, rdata, stk_wdata, stk_rdata, alu_res;
   logic [11:0]           pc, pc_vec;
   logic [15:0]           stk_addr;
   logic [4:0]            alu_dst;
   int                    miscompares, checks_done;
   logic [7:0]            alu_exp [6] = '{8'hD2, 8'h5A, 8'h14, 8'hBE, 8'hAA, 8'h3C};

   ies_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata), .src_event_i(ev),
      .src_level_i(lvl), .instr_boundary_i(bnd), .sei_i(sei), .cli_i(cli), .return_from_irq_op_i(ret_op),
      .sleep_i(slp), .pc_i(pc), .stk_rdata_i(stk_rdata), .alu_i(alu), .reset_vector_boot_fuse_i(fuse),
      .app_section_lock_bit_i(alock), .boot_section_lock_bit_i(blk), .stall_o(stall), .pc_load_o(pc_load),
      .pc_vec_o(pc_vec), .stk_we_o(stk_we), .stk_re_o(stk_re), .stk_addr_o(stk_addr),
      .stk_wdata_o(stk_wdata), .gie_o(gie), .alu_wr_o(alu_wr), .alu_dst_o(alu_dst), .alu_res_o(alu_res));
   ies_stack_model u_mdl (.clock_i(clock_i), .stk_we_i(stk_we), .stk_re_i(stk_re), .stk_addr_i(stk_addr),
      .stk_wdata_i(stk_wdata), .stk_rdata_o(stk_rdata));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clock_i);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_i);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clock_i);
      bus.rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask : rd

   task automatic fire(input logic [7:0] m);
      @(posedge clock_i);
      ev <= m;
      @(posedge clock_i);
      ev <= 8'h00;
   endtask : fire

   // counts cycles from the taking edge until the pc load pulse
   task automatic wait_load(input logic [15:0] lat, input logic [15:0] vec);
      int n;
      n = 1;
      #1;
      while (pc_load !== 1'b1 && n < 20) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (n == 20) begin
         miscompares++;
         finish_test();
      end
      if (lat != 16'h0000) chk("latency", lat, n[15:0]);
      chk("vector", vec, {4'h0, pc_vec});
   endtask : wait_load

   task automatic step_in(input logic c);
      @(posedge clock_i);
      bnd <= 1'b1;
      cli <= c;
      @(posedge clock_i);
      bnd <= 1'b0;
      cli <= 1'b0;
   endtask : step_in

   task automatic take(input logic [15:0] v);
      step_in(1'b0);
      wait_load(16'h0005, v);
   endtask : take

   task automatic refuse(input logic c);
      logic h;
      h = 1'b0;
      step_in(c);
      repeat (7) begin
         @(posedge clock_i);
         #1;
         h = h | stall;
      end
      chk("stall", 16'h0000, {15'h0000, h});
   endtask : refuse

   task automatic reset_to(input logic f, input logic [15:0] v);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      fuse    <= f;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      wait_load(16'h0000, v);
   endtask : reset_to

   initial begin
      miscompares = 0;
      checks_done = 0;
      {rst_n_i, bnd, sei, cli, ret_op, slp, fuse, alock, blk} = '0;
      {bus, alu, ev, lvl, pc} = '0;
      reset_to(1'b1, 16'h0C00);
      reset_to(1'b0, 16'h0000);
      alu.a <= 8'h96;
      alu.b <= 8'h3C;
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_i);
         alu.op  <= ies_pkg::ies_op_t'(i);
         alu.dst <= 5'(i + 3);
         alu.go  <= 1'b1;
         @(posedge clock_i);
         alu.go <= 1'b0;
         #1;
         chk("alu_res", {8'h00, alu_exp[i]}, {8'h00, alu_res});
         chk("alu_dst", 16'(i + 3), {11'h000, alu_dst});
         chk("alu_wr", 16'h0001, {15'h0000, alu_wr});
      end
      wr(ies_pkg::A_SPL, 8'h00);
      wr(ies_pkg::A_SPH, 8'h01);
      wr(4'h9, 8'hFF);
      rd(4'h9, 8'h00);
      wr(ies_pkg::A_EN, 8'h04);
      fire(8'h05);
      wr(ies_pkg::A_FLAG, 8'h00);
      rd(ies_pkg::A_FLAG, 8'h05);
      wr(ies_pkg::A_FLAG, 8'h01);
      rd(ies_pkg::A_FLAG, 8'h04);
      rd(ies_pkg::A_PEND, 8'h04);
      rd(ies_pkg::A_SEQ, 8'h20);
      refuse(1'b0);
      wr(ies_pkg::A_STATUS, 8'h95);
      pc <= 12'h123;
      take(16'h0003);
      chk("gie", 16'h0000, {15'h0000, gie});
      rd(ies_pkg::A_STATUS, 8'h15);
      rd(ies_pkg::A_FLAG, 8'h00);
      rd(ies_pkg::A_SPL, 8'hFE);
      chk("push_lo", 16'h0023, {8'h00, u_mdl.mem[10'h100]});
      chk("push_hi", 16'h0001, {8'h00, u_mdl.mem[10'h0FF]});
      fire(8'h04);
      @(posedge clock_i);
      ret_op <= 1'b1;
      @(posedge clock_i);
      ret_op <= 1'b0;
      wait_load(16'h0005, 16'h0123);
      chk("gie", 16'h0001, {15'h0000, gie});
      rd(ies_pkg::A_SPL, 8'h00);
      rd(ies_pkg::A_STATUS, 8'h95);
      refuse(1'b0);
      take(16'h0003);
      wr(ies_pkg::A_EN, 8'h22);
      fire(8'h22);
      @(posedge clock_i);
      sei <= 1'b1;
      @(posedge clock_i);
      sei <= 1'b0;
      refuse(1'b0);
      take(16'h0002);
      wr(ies_pkg::A_STATUS, 8'h80);
      take(16'h0006);
      fire(8'h02);
      wr(ies_pkg::A_STATUS, 8'h80);
      refuse(1'b1);
      chk("gie", 16'h0000, {15'h0000, gie});
      wr(ies_pkg::A_CTRL, 8'h02);
      wr(ies_pkg::A_STATUS, 8'h80);
      take(16'h0C02);
      wr(ies_pkg::A_EN, 8'h08);
      fire(8'h08);
      blk <= 1'b1;
      repeat (4) @(posedge clock_i);
      wr(ies_pkg::A_STATUS, 8'h80);
      refuse(1'b0);
      @(posedge clock_i);
      blk <= 1'b0;
      repeat (5) @(posedge clock_i);
      slp <= 1'b1;
      @(posedge clock_i);
      wait_load(16'h0009, 16'h0C04);
      @(posedge clock_i);
      slp <= 1'b0;
      wr(ies_pkg::A_CTRL, 8'h00);
      wr(ies_pkg::A_EN, 8'h00);
      lvl <= 8'h80;
      @(posedge clock_i);
      lvl <= 8'h00;
      wr(ies_pkg::A_EN, 8'h80);
      wr(ies_pkg::A_STATUS, 8'h80);
      refuse(1'b0);
      @(posedge clock_i);
      lvl <= 8'h80;
      take(16'h0008);
      finish_test();
   end
endmodule : interrupt_entry_sequencer_bench
